// *** hw/atomic_sync_wait_unit.sv ***
`timescale 1ns/1ps
`include "atomic_sync_wait_regs.svh"
// How it works
// - linked load fetches word, sets link flag
// - linked load address: base plus 9-bit displacement
// - one sequence; new linked load replaces it
// - misaligned linked/conditional address raises address error
// - linked load never disturbs other cores' stores
// - store only with link; report 1 or 0
// - conditional store address: base plus 16-bit displacement
// - exception return makes conditional store fail
// - memory port carries lock; external may fail store
// - exception between pair makes store fail
// - barrier: earlier accesses finish before later start
// - loads complete on writeback, stores when visible
// - barrier signalled on the memory port
// - every barrier type does full synchronization
// - standby stalls, drains, then stops main clock
// - resets, nmi, enabled or debug interrupt wake
// - wake interrupt taken, saved pc after standby
// - no coprocessor 0 access: coprocessor unusable
// - standby in delay/forbidden slot: reserved instruction
// - standby code field is ignored
// - interrupt return makes conditional store fail

module atomic_sync_wait_unit (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // avalon-mm register slave
  input wire logic [`ASW_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // pipeline request
  input wire logic op_valid_i,
  input wire atomic_sync_wait_pkg::op_t op_i,
  input wire logic [31:0] base_i,
  input wire logic [15:0] offset_i,
  input wire logic [31:0] store_data_i,
  input wire logic [4:0] barrier_type_i,
  input wire logic [31:0] pc_i,
  input wire logic in_branch_slot_i,
  input wire logic exception_taken_i,
  // pipeline answer
  output logic op_ready_o,
  output logic done_o,
  output logic wb_en_o,
  output logic [31:0] result_o,
  output logic addr_err_o,
  output logic cop_unusable_o,
  output logic reserved_insn_o,
  output logic irq_take_o,
  output logic [31:0] saved_exception_pc_o,
  // memory interface
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_lock_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_sync_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_store_fail_i,
  input wire logic mem_outstanding_i,
  // standby and wake
  output logic clk_run_o,
  input wire logic warm_reset_n_i,
  input wire logic cold_reset_n_i,
  input wire logic nmi_i,
  input wire logic int_req_i,
  input wire logic debug_irq_in_i
);

  atomic_sync_wait_pkg::regs_t r_ff; // registered state
  atomic_sync_wait_pkg::regs_t nxt_r; // next state

  logic [31:0] load_addr; // linked load effective address
  logic [31:0] store_addr; // conditional store effective address
  logic [31:0] reg_rd; // register read mux
  logic sys_reset; // warm or cold reset asserted
  logic wake; // any standby wake source
  logic store_ok; // outcome of a locked store

  // effective addresses from sign-extended displacements
  always_comb begin
    load_addr = base_i + {{(32-`ASW_LOAD_DISP_W){offset_i[`ASW_LOAD_DISP_W-1]}},
                          offset_i[`ASW_LOAD_DISP_W-1:0]};
    store_addr = base_i + {{(32-`ASW_STORE_DISP_W){offset_i[`ASW_STORE_DISP_W-1]}},
                           offset_i};
  end

  // wake sources and register read view
  always_comb begin
    sys_reset = !warm_reset_n_i || !cold_reset_n_i;
    wake = sys_reset || nmi_i || int_req_i || debug_irq_in_i;
    store_ok = !(r_ff.lock_en && mem_store_fail_i);
    reg_rd = 32'h0000_0000;
    case (avs_address_i)
      `ASW_REG_CTRL: begin
        reg_rd[`ASW_CTRL_CP0_EN_BIT] = r_ff.cp0_en;
        reg_rd[`ASW_CTRL_LOCK_EN_BIT] = r_ff.lock_en;
      end
      `ASW_REG_STATUS: begin
        reg_rd[`ASW_STAT_LINK_BIT] = r_ff.link_flag;
        reg_rd[`ASW_STAT_STANDBY_BIT] = (r_ff.st == atomic_sync_wait_pkg::st_standby);
        reg_rd[`ASW_STAT_BUSY_BIT] = !r_ff.op_ready;
        reg_rd[`ASW_STAT_CLKRUN_BIT] = r_ff.clk_run;
      end
      `ASW_REG_SCCNT: begin
        reg_rd[`ASW_SCCNT_OK_LSB +: 16] = r_ff.store_ok_cnt;
        reg_rd[`ASW_SCCNT_FAIL_LSB +: 16] = r_ff.store_fail_cnt;
      end
      // unmapped addresses read zero
      default: begin
        reg_rd = 32'h0000_0000;
      end
    endcase
  end

  // next-state logic for bus slave and sequencer
  always_comb begin
    nxt_r = r_ff;
    // single-cycle pulses fall by default
    nxt_r.done = 1'h0;
    nxt_r.wb_en = 1'h0;
    nxt_r.addr_err = 1'h0;
    nxt_r.cpu_err = 1'h0;
    nxt_r.ri_err = 1'h0;
    nxt_r.irq_take = 1'h0;
    nxt_r.mem_sync = 1'h0;

    // avalon slave: answer one cycle after the request, then rearm
    if (avs_read_i || avs_write_i) begin
      if (r_ff.avs_wait) begin
        nxt_r.avs_wait = 1'h0;
        nxt_r.avs_rdata = reg_rd;
      end else begin
        nxt_r.avs_wait = 1'h1;
        // write takes effect on the edge the master sees waitrequest low
        if (avs_write_i) begin
          if (avs_address_i == `ASW_REG_CTRL) begin
            nxt_r.cp0_en = avs_writedata_i[`ASW_CTRL_CP0_EN_BIT];
            nxt_r.lock_en = avs_writedata_i[`ASW_CTRL_LOCK_EN_BIT];
          end else if (avs_address_i == `ASW_REG_SCCNT) begin
            // any write clears both counters
            nxt_r.store_ok_cnt = 16'h0000;
            nxt_r.store_fail_cnt = 16'h0000;
          end
        end
      end
    end else begin
      nxt_r.avs_wait = 1'h1;
    end

    // reset pins and exception entry abandon the sequence
    if (sys_reset || exception_taken_i) begin
      nxt_r.link_flag = 1'h0;
    end

    case (r_ff.st)
      // accept a new operation
      atomic_sync_wait_pkg::st_idle: begin
        if (op_valid_i && r_ff.op_ready) begin
          case (op_i)
            atomic_sync_wait_pkg::op_linked_load: begin
              if ((load_addr[1:0] & `ASW_ALIGN_MASK) != 2'h0) begin
                nxt_r.addr_err = 1'h1;
                nxt_r.done = 1'h1;
              end else begin
                // plain read, no lock: other cores keep their links
                nxt_r.mem_req = 1'h1;
                nxt_r.mem_we = 1'h0;
                nxt_r.mem_lock = 1'h0;
                nxt_r.mem_addr = load_addr;
                nxt_r.st = atomic_sync_wait_pkg::st_load_mem;
              end
            end
            atomic_sync_wait_pkg::op_conditional_store: begin
              if ((store_addr[1:0] & `ASW_ALIGN_MASK) != 2'h0) begin
                nxt_r.addr_err = 1'h1;
                nxt_r.done = 1'h1;
              end else if (r_ff.link_flag && !sys_reset && !exception_taken_i) begin
                // locked write; external lock logic may still refuse it
                nxt_r.mem_req = 1'h1;
                nxt_r.mem_we = 1'h1;
                nxt_r.mem_lock = 1'h1;
                nxt_r.mem_addr = store_addr;
                nxt_r.mem_wdata = store_data_i;
                nxt_r.st = atomic_sync_wait_pkg::st_store_mem;
              end else begin
                // no link: memory untouched, report failure
                nxt_r.result = 32'h0000_0000;
                nxt_r.wb_en = 1'h1;
                nxt_r.done = 1'h1;
                nxt_r.store_fail_cnt = r_ff.store_fail_cnt + 16'h0001;
              end
            end
            atomic_sync_wait_pkg::op_barrier: begin
              // type field is not decoded: all types do the full barrier
              nxt_r.st = atomic_sync_wait_pkg::st_sync_drain;
            end
            atomic_sync_wait_pkg::op_standby: begin
              // the code field has no port and is never looked at
              if (in_branch_slot_i) begin
                nxt_r.ri_err = 1'h1;
                nxt_r.done = 1'h1;
              end else if (!r_ff.cp0_en) begin
                nxt_r.cpu_err = 1'h1;
                nxt_r.done = 1'h1;
              end else begin
                nxt_r.saved_exception_pc = pc_i + `ASW_INSN_BYTES;
                nxt_r.st = atomic_sync_wait_pkg::st_wait_drain;
              end
            end
            atomic_sync_wait_pkg::op_exception_return: begin
              nxt_r.link_flag = 1'h0;
              nxt_r.done = 1'h1;
            end
            atomic_sync_wait_pkg::op_interrupt_return: begin
              nxt_r.link_flag = 1'h0;
              nxt_r.done = 1'h1;
            end
            // nothing to do for other codes
            default: begin
              nxt_r.done = 1'h1;
            end
          endcase
        end
      end
      // linked load waiting for read data
      atomic_sync_wait_pkg::st_load_mem: begin
        if (mem_ack_i) begin
          nxt_r.mem_req = 1'h0;
          nxt_r.result = mem_rdata_i;
          nxt_r.wb_en = 1'h1;
          nxt_r.done = 1'h1;
          // set wins over a same-cycle clear; replaces older sequence
          nxt_r.link_flag = 1'h1;
          nxt_r.st = atomic_sync_wait_pkg::st_idle;
        end
      end
      // conditional store waiting for the locked write to finish
      atomic_sync_wait_pkg::st_store_mem: begin
        if (mem_ack_i) begin
          nxt_r.mem_req = 1'h0;
          nxt_r.mem_we = 1'h0;
          nxt_r.mem_lock = 1'h0;
          nxt_r.result = {31'h0000_0000, store_ok};
          nxt_r.wb_en = 1'h1;
          nxt_r.done = 1'h1;
          nxt_r.link_flag = 1'h0;
          if (store_ok) begin
            nxt_r.store_ok_cnt = r_ff.store_ok_cnt + 16'h0001;
          end else begin
            nxt_r.store_fail_cnt = r_ff.store_fail_cnt + 16'h0001;
          end
          nxt_r.st = atomic_sync_wait_pkg::st_idle;
        end
      end
      // barrier: hold later accesses until earlier ones are done
      atomic_sync_wait_pkg::st_sync_drain: begin
        // outstanding stays high until load writeback / store visibility
        if (!mem_outstanding_i) begin
          nxt_r.mem_sync = 1'h1;
          nxt_r.done = 1'h1;
          nxt_r.st = atomic_sync_wait_pkg::st_idle;
        end
      end
      // standby: pipeline stalled, drain external requests
      atomic_sync_wait_pkg::st_wait_drain: begin
        if (wake) begin
          nxt_r.st = atomic_sync_wait_pkg::st_standby;
        end else if (!mem_outstanding_i) begin
          nxt_r.clk_run = 1'h0;
          nxt_r.st = atomic_sync_wait_pkg::st_standby;
        end
      end
      // low power until a wake source
      atomic_sync_wait_pkg::st_standby: begin
        if (wake) begin
          nxt_r.clk_run = 1'h1;
          nxt_r.done = 1'h1;
          if (int_req_i && !nmi_i && !debug_irq_in_i && !sys_reset) begin
            // interrupt taken before the next instruction
            nxt_r.irq_take = 1'h1;
            nxt_r.link_flag = 1'h0;
          end
          nxt_r.st = atomic_sync_wait_pkg::st_idle;
        end
      end
      // unknown state recovers to idle
      default: begin
        nxt_r.st = atomic_sync_wait_pkg::st_idle;
      end
    endcase

    // one sequence at a time: accept only from idle
    nxt_r.op_ready = (nxt_r.st == atomic_sync_wait_pkg::st_idle);
  end

  // state register
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      r_ff.st <= atomic_sync_wait_pkg::st_idle;
      r_ff.link_flag <= 1'h0;
      r_ff.cp0_en <= `ASW_CTRL_CP0_EN_RST;
      r_ff.lock_en <= `ASW_CTRL_LOCK_EN_RST;
      r_ff.avs_wait <= 1'h1;
      r_ff.avs_rdata <= `ASW_RDATA_RST;
      r_ff.mem_req <= 1'h0;
      r_ff.mem_we <= 1'h0;
      r_ff.mem_lock <= 1'h0;
      r_ff.mem_addr <= 32'h0000_0000;
      r_ff.mem_wdata <= 32'h0000_0000;
      r_ff.mem_sync <= 1'h0;
      r_ff.op_ready <= 1'h1;
      r_ff.done <= 1'h0;
      r_ff.wb_en <= 1'h0;
      r_ff.result <= 32'h0000_0000;
      r_ff.addr_err <= 1'h0;
      r_ff.cpu_err <= 1'h0;
      r_ff.ri_err <= 1'h0;
      r_ff.irq_take <= 1'h0;
      r_ff.saved_exception_pc <= 32'h0000_0000;
      r_ff.clk_run <= 1'h1;
      r_ff.store_ok_cnt <= 16'h0000;
      r_ff.store_fail_cnt <= 16'h0000;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from the state register
  always_comb begin
    avs_readdata_o = r_ff.avs_rdata;
    avs_waitrequest_o = r_ff.avs_wait;
    op_ready_o = r_ff.op_ready;
    done_o = r_ff.done;
    wb_en_o = r_ff.wb_en;
    result_o = r_ff.result;
    addr_err_o = r_ff.addr_err;
    cop_unusable_o = r_ff.cpu_err;
    reserved_insn_o = r_ff.ri_err;
    irq_take_o = r_ff.irq_take;
    saved_exception_pc_o = r_ff.saved_exception_pc;
    mem_req_o = r_ff.mem_req;
    mem_we_o = r_ff.mem_we;
    mem_lock_o = r_ff.mem_lock;
    mem_addr_o = r_ff.mem_addr;
    mem_wdata_o = r_ff.mem_wdata;
    mem_sync_o = r_ff.mem_sync;
    clk_run_o = r_ff.clk_run;
  end

endmodule

// *** inc/atomic_sync_wait_pkg.sv ***
package atomic_sync_wait_pkg;

  // operation presented by the pipeline
  typedef enum logic [2:0] {
    op_none,
    op_linked_load,
    op_conditional_store,
    op_barrier,
    op_standby,
    op_exception_return,
    op_interrupt_return
  } op_t;

  // sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_load_mem,
    st_store_mem,
    st_sync_drain,
    st_wait_drain,
    st_standby
  } state_t;

  // whole state of the unit
  typedef struct packed {
    state_t st;
    logic link_flag;
    logic cp0_en;
    logic lock_en;
    logic avs_wait;
    logic [31:0] avs_rdata;
    logic mem_req;
    logic mem_we;
    logic mem_lock;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic mem_sync;
    logic op_ready;
    logic done;
    logic wb_en;
    logic [31:0] result;
    logic addr_err;
    logic cpu_err;
    logic ri_err;
    logic irq_take;
    logic [31:0] saved_exception_pc;
    logic clk_run;
    logic [15:0] store_ok_cnt;
    logic [15:0] store_fail_cnt;
  } regs_t;

endpackage

// *** inc/atomic_sync_wait_regs.svh ***
`ifndef ATOMIC_SYNC_WAIT_REGS_SVH
`define ATOMIC_SYNC_WAIT_REGS_SVH

// register byte addresses on the avalon slave
`define ASW_AW 4
`define ASW_REG_CTRL 4'h0
`define ASW_REG_STATUS 4'h4
`define ASW_REG_SCCNT 4'h8

// control register fields
`define ASW_CTRL_CP0_EN_BIT 0
`define ASW_CTRL_LOCK_EN_BIT 1
`define ASW_CTRL_CP0_EN_RST 1'h1
`define ASW_CTRL_LOCK_EN_RST 1'h1

// status register fields
`define ASW_STAT_LINK_BIT 0
`define ASW_STAT_STANDBY_BIT 1
`define ASW_STAT_BUSY_BIT 2
`define ASW_STAT_CLKRUN_BIT 3

// conditional store counters: success low half, failure high half
`define ASW_SCCNT_OK_LSB 0
`define ASW_SCCNT_FAIL_LSB 16

// displacement widths and alignment
`define ASW_LOAD_DISP_W 9
`define ASW_STORE_DISP_W 16
`define ASW_ALIGN_MASK 2'h3
`define ASW_INSN_BYTES 32'h0000_0004

// reset value of readdata
`define ASW_RDATA_RST 32'h0000_0000

`endif

// *** tb/atomic_sync_wait_chk.sv ***
`timescale 1ns/1ps
module atomic_sync_wait_chk (
  // clock, reset and pipeline side
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic op_valid_i,
  input wire atomic_sync_wait_pkg::op_t op_i,
  input wire logic [31:0] base_i,
  input wire logic [15:0] offset_i,
  input wire logic in_branch_slot_i,
  input wire logic op_ready_o,
  input wire logic done_o,
  input wire logic wb_en_o,
  input wire logic [31:0] result_o,
  input wire logic addr_err_o,
  input wire logic reserved_insn_o,
  input wire logic irq_take_o,
  // memory side
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic mem_lock_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_sync_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_store_fail_i,
  input wire logic mem_outstanding_i,
  // standby and wake
  input wire logic clk_run_o,
  input wire logic nmi_i,
  input wire logic int_req_i,
  input wire logic debug_irq_in_i,
  input wire logic warm_reset_n_i,
  input wire logic cold_reset_n_i
);
  default clocking
    @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  logic ld_t, st_t, mis; // load or store taken; low address bits set
  logic [31:0] ea9, ea16; // effective addresses of both displacement forms
  assign ld_t = op_valid_i && op_ready_o && op_i == atomic_sync_wait_pkg::op_linked_load;
  assign st_t = op_valid_i && op_ready_o && op_i == atomic_sync_wait_pkg::op_conditional_store;
  assign mis = |(base_i[1:0] + offset_i[1:0]);
  assign ea9 = base_i + {{23{offset_i[8]}}, offset_i[8:0]};
  assign ea16 = base_i + {{16{offset_i[15]}}, offset_i};
  a_misalign_err: assert property (
    (ld_t || st_t) && mis |=> addr_err_o && done_o && !mem_req_o) else $error("no fault");
  a_load_addr: assert property (
    ld_t && !mis |=> mem_req_o && !mem_we_o && !mem_lock_o && mem_addr_o == $past(ea9))
    else $error("bad load request");
  a_store_addr: assert property (
    st_t && !mis |=> !mem_req_o || (mem_we_o && mem_lock_o && mem_addr_o == $past(ea16)))
    else $error("bad store request");
  a_req_held: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("request dropped early");
  a_load_wb: assert property (
    mem_req_o && !mem_we_o && mem_ack_i |=> done_o && wb_en_o && result_o == $past(mem_rdata_i))
    else $error("load data not written back");
  a_store_ok: assert property (
    mem_req_o && mem_we_o && mem_ack_i && !mem_store_fail_i |=> wb_en_o && result_o == 32'h1)
    else $error("store success not reported");
  a_sync_drain: assert property (
    mem_sync_o |-> done_o && !$past(mem_outstanding_i)) else $error("barrier not drained");
  a_stop_drained: assert property (
    $fell(clk_run_o) |-> !$past(mem_outstanding_i) && !mem_req_o)
    else $error("clock stopped early");
  a_wake_irq: assert property (
    !clk_run_o && int_req_i && !nmi_i && !debug_irq_in_i && warm_reset_n_i && cold_reset_n_i
    |=> clk_run_o && irq_take_o && done_o) else $error("interrupt wake missed");
  a_slot_ri: assert property (
    op_valid_i && op_ready_o && op_i == atomic_sync_wait_pkg::op_standby && in_branch_slot_i
    |=> reserved_insn_o && done_o) else $error("slot standby not refused");
  c_sync: cover property (mem_sync_o);
  c_irq: cover property (irq_take_o);
  c_refused: cover property (mem_req_o && mem_we_o && mem_ack_i && mem_store_fail_i);
endmodule

bind atomic_sync_wait_unit atomic_sync_wait_chk chk (
  .mclk_i, .reset_i, .op_valid_i, .op_i, .base_i, .offset_i, .in_branch_slot_i, .op_ready_o,
  .done_o, .wb_en_o, .result_o, .addr_err_o, .reserved_insn_o, .irq_take_o, .mem_req_o,
  .mem_we_o, .mem_lock_o, .mem_addr_o, .mem_sync_o, .mem_ack_i, .mem_rdata_i, .mem_store_fail_i,
  .mem_outstanding_i, .clk_run_o, .nmi_i, .int_req_i, .debug_irq_in_i, .warm_reset_n_i,
  .cold_reset_n_i);

// *** tb/atomic_sync_wait_unit_bench.sv ***
`timescale 1ns/1ps
module atomic_sync_wait_unit_bench;
  // design inputs, all valued at time zero
  logic mclk_i = 1'h0, reset_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, base_i = 32'h0, store_data_i = 32'h0, pc_i = 32'h0;
  logic op_valid_i = 1'h0, in_branch_slot_i = 1'h0, exception_taken_i = 1'h0;
  atomic_sync_wait_pkg::op_t op_i = atomic_sync_wait_pkg::op_none;
  logic [15:0] offset_i = 16'h0;
  logic [4:0] barrier_type_i = 5'h0;
  logic mem_outstanding_i = 1'h0, nmi_i = 1'h0, int_req_i = 1'h0, debug_irq_in_i = 1'h0;
  logic warm_reset_n_i = 1'h1, cold_reset_n_i = 1'h1, fail = 1'h0;
  logic [1:0] dly = 2'h0; // partner answer delay
  // design outputs and partner lines
  logic [31:0] avs_readdata_o, result_o, saved_exception_pc_o, mem_addr_o, mem_wdata_o;
  logic [31:0] mem_rdata_i, wr_d;
  logic avs_waitrequest_o, op_ready_o, done_o, wb_en_o, addr_err_o, cop_unusable_o;
  logic reserved_insn_o, irq_take_o, mem_req_o, mem_we_o, mem_lock_o, mem_sync_o;
  logic mem_ack_i, mem_store_fail_i, clk_run_o;
  logic [7:0] wr_n;
  // outputs captured in the completion cycle
  logic [31:0] res;
  logic wb, aerr, cu, ri, irq, sync;
  int err_total = 0, n_compared = 0;
  localparam atomic_sync_wait_pkg::op_t k_load = atomic_sync_wait_pkg::op_linked_load;
  localparam atomic_sync_wait_pkg::op_t k_store = atomic_sync_wait_pkg::op_conditional_store;
  localparam atomic_sync_wait_pkg::op_t k_wait = atomic_sync_wait_pkg::op_standby;

  atomic_sync_wait_unit dut (.*);
  mem_partner mem (.mclk_i, .reset_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .mem_store_fail_o(mem_store_fail_i), .delay_i(dly), .fail_i(fail),
    .wr_count_o(wr_n), .wr_data_o(wr_d));

  // expected memory word and effective address
  function automatic logic [31:0] mem_val(input logic [31:0] a);
    return a ^ 32'ha5a5_0f0f;
  endfunction
  function automatic logic [31:0] ea9(input logic [31:0] b, input logic [15:0] o);
    return b + {{23{o[8]}}, o[8:0]};
  endfunction

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    do @(posedge mclk_i); while (avs_waitrequest_o);
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask

  // one pipeline operation; outputs taken in its done cycle
  task automatic op(input atomic_sync_wait_pkg::op_t k, input logic [31:0] b,
                    input logic [15:0] o, input logic [31:0] d, input logic s);
    @(posedge mclk_i);
    op_valid_i <= 1'h1;
    op_i <= k;
    base_i <= b;
    pc_i <= b;
    offset_i <= o;
    store_data_i <= d;
    in_branch_slot_i <= s;
    @(negedge mclk_i);
    while (!op_ready_o) @(negedge mclk_i);
    @(posedge mclk_i);
    op_valid_i <= 1'h0;
    @(negedge mclk_i);
    while (!done_o) @(negedge mclk_i);
    {wb, res, aerr, cu, ri, irq, sync} = {wb_en_o, result_o, addr_err_o, cop_unusable_o,
      reserved_insn_o, irq_take_o, mem_sync_o};
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // free-running clock and hang watchdog
  initial forever #4 mclk_i = ~mclk_i;
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    logic [31:0] r, b, w;
    logic [15:0] o;
    logic [7:0] n;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'h0;
    r = $urandom(19015);
    bus(1'h0, 4'h0, 32'h0, r);
    check(r, 32'h3);
    bus(1'h0, 4'h4, 32'h0, r);
    check(r, 32'h8);
    $display("test reset values done");
    // replaced load then store; first pass tells 9-bit from 16-bit displacement
    for (int k = 0; k < 6; k++) begin
      b = $urandom & 32'hffff_fffc;
      o = (k == 0) ? 16'h0100 : 16'($urandom) & 16'hfffc;
      w = $urandom;
      dly <= 2'($urandom);
      op(k_load, $urandom & 32'hffff_fffc, o, w, 1'h0);
      op(k_load, b, o, w, 1'h0);
      check({wb, res}, {1'h1, mem_val(ea9(b, o))});
      n = wr_n;
      op(k_store, b, o, w, 1'h0);
      check({res, wr_n - n, wr_d}, {32'h1, 8'h1, w});
    end
    n = wr_n;
    op(k_store, b, o, w, 1'h0);
    check({res, wr_n - n}, 40'h0);
    $display("test load and store done");
    // events between the pair that must make the store fail
    for (int k = 0; k < 5; k++) begin
      op(k_load, b, o, w, 1'h0);
      if (k == 0) op(atomic_sync_wait_pkg::op_exception_return, b, o, w, 1'h0);
      if (k == 1) op(atomic_sync_wait_pkg::op_interrupt_return, b, o, w, 1'h0);
      @(posedge mclk_i);
      exception_taken_i <= (k == 2);
      reset_i <= (k == 3);
      fail <= (k == 4);
      @(posedge mclk_i);
      exception_taken_i <= 1'h0;
      reset_i <= 1'h0;
      n = wr_n;
      op(k_store, b, o, w, 1'h0);
      check({res, wr_n - n}, 40'h0);
    end
    fail <= 1'h0;
    // misaligned addresses on both instructions
    for (int k = 1; k < 4; k++) begin
      op(k_load, b | 32'(k), o, w, 1'h0);
      check(aerr, 1'h1);
      op(k_load, b, o, w, 1'h0);
      n = wr_n;
      op(k_store, b, o | 16'(k), w, 1'h0);
      check({aerr, wr_n - n}, 9'h100);
    end
    $display("test failing stores done");
    // barrier of both type extremes waits for outstanding accesses
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      barrier_type_i <= (k == 1) ? 5'h1f : 5'h0;
      mem_outstanding_i <= 1'h1;
      fork
        op(atomic_sync_wait_pkg::op_barrier, b, o, w, 1'h0);
        begin
          repeat (6) begin
            @(negedge mclk_i);
            check(done_o, 1'h0);
          end
          @(posedge mclk_i);
          mem_outstanding_i <= 1'h0;
        end
      join
      check(sync, 1'h1);
    end
    $display("test barrier done");
    // standby: drain, stop clock, then each wake source
    for (int k = 0; k < 5; k++) begin
      b = $urandom & 32'hffff_fffc;
      @(posedge mclk_i);
      mem_outstanding_i <= 1'h1;
      fork
        op(k_wait, b, o, w, 1'h0);
        begin
          repeat (4) begin
            @(negedge mclk_i);
            check(clk_run_o, 1'h1);
          end
          @(posedge mclk_i);
          mem_outstanding_i <= 1'h0;
          @(negedge mclk_i);
          while (clk_run_o) @(negedge mclk_i);
          @(posedge mclk_i);
          int_req_i <= (k == 0);
          nmi_i <= (k == 1);
          debug_irq_in_i <= (k == 2);
          warm_reset_n_i <= (k != 3);
          cold_reset_n_i <= (k != 4);
          @(posedge mclk_i);
          {int_req_i, nmi_i, debug_irq_in_i, warm_reset_n_i, cold_reset_n_i} <= 5'h03;
        end
      join
      check({irq, cu, ri}, {k == 0, 2'h0});
      if (k == 0) check(saved_exception_pc_o, b + 32'h4);
    end
    op(k_wait, b, o, w, 1'h1);
    check({ri, clk_run_o}, 2'h3);
    bus(1'h1, 4'h0, 32'hffff_fffe, r);
    bus(1'h0, 4'h0, 32'h0, r);
    check(r, 32'h2);
    op(k_wait, b, o, w, 1'h0);
    check({cu, clk_run_o}, 2'h3);
    // since the mid-run reset: one unlinked and one refused store failed
    bus(1'h0, 4'h8, 32'h0, r);
    check(r, 32'h0002_0000);
    bus(1'h1, 4'h0, 32'h3, r);
    bus(1'h1, 4'h8, 32'h0, r);
    bus(1'h1, 4'hc, 32'hffff_ffff, r);
    bus(1'h0, 4'h8, 32'h0, r);
    check(r, 32'h0);
    bus(1'h0, 4'hc, 32'h0, r);
    check(r, 32'h0);
    $display("test standby and registers done");
    summarize();
  end
endmodule

// *** tb/mem_partner.sv ***
`timescale 1ns/1ps
// far-side memory: answers after a chosen delay and may refuse a locked store
module mem_partner (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // memory port of the unit
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o,
  output logic mem_store_fail_o,
  // bench control and observation
  input wire logic [1:0] delay_i,
  input wire logic fail_i,
  output logic [7:0] wr_count_o,
  output logic [31:0] wr_data_o
);
  logic [1:0] wait_ff; // cycles waited on the current request
  // one ack per request; answer lines toggle while not answering
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_ack_o <= 1'h0;
      mem_rdata_o <= 32'h0;
      mem_store_fail_o <= 1'h0;
      wr_count_o <= 8'h0;
      wr_data_o <= 32'h0;
      wait_ff <= 2'h0;
    end else begin
      mem_ack_o <= 1'h0;
      mem_rdata_o <= ~mem_rdata_o;
      mem_store_fail_o <= ~mem_store_fail_o;
      if (mem_req_i && !mem_ack_o) begin
        wait_ff <= wait_ff + 2'h1;
        if (wait_ff >= delay_i) begin
          mem_ack_o <= 1'h1;
          mem_rdata_o <= mem_addr_i ^ 32'ha5a5_0f0f;
          mem_store_fail_o <= fail_i;
          wait_ff <= 2'h0;
          // a refused store leaves memory untouched
          if (mem_we_i && !fail_i) begin
            wr_count_o <= wr_count_o + 8'h1;
            wr_data_o <= mem_wdata_i;
          end
        end
      end
    end
  end
endmodule
